// ### core/dtc_timer.sv
/*
 * Two counter/timers with mode select, gating, clock select, prescaling and an
 * overflow interrupt with status/mask registers.
 * Assumes a plain register port with read data one cycle after the read strobe, and
 * asynchronous pins for event, gate and external clock inputs.
 */
// Chosen here: the plain strobed port.
`default_nettype none
module dtc_timer
   import dtc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Pins
   input wire logic timer0_event_pin_in,
   input wire logic timer1_event_pin_in,
   input wire logic ext_input_zero_in,
   input wire logic ext_input_one_in,
   input wire logic ext_clk_in,
   // Interrupt
   output logic irq_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [7:0] timer_mode_ctrl;
      logic [7:0] timer_clock_ctrl;
      logic [7:0] timer_control_reg;
      logic [7:0] ext_input_config;
      logic [7:0] timer0_low_byte;
      logic [7:0] timer0_high_byte;
      logic [7:0] timer1_low_byte;
      logic [7:0] timer1_high_byte;
      logic [DTC_IRQ_W-1:0] irq_stat;
      logic [DTC_IRQ_W-1:0] irq_mask;
      logic [7:0] rdata;
   } dtc_state_t;

   dtc_state_t st, next_st;
   logic pre_tick;
   logic [4:0] fall;

   // Count one step of a timer: returns {overflow, new high, new low}
   function automatic logic [16:0] dtc_step(input logic [1:0] mode, input logic [7:0] lo,
                                            input logic [7:0] hi);
      logic [16:0] r;
      logic [15:0] w;
      r = {1'b0, hi, lo};
      w = {hi, lo} + 16'h0_001;
      case (mode)
         DTC_MODE_13: begin
            if (lo[4:0] == 5'h1_f) begin
               r = {(hi == 8'hff), hi + 8'h01, 3'h0, 5'h0_0};
            end else begin
               r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h0_1};
            end
         end
         DTC_MODE_16: r = {({hi, lo} == 16'hffff), w};
         DTC_MODE_RELOAD: begin
            if (lo == 8'hff) begin
               r = {1'b1, hi, hi};
            end else begin
               r = {1'b0, hi, lo + 8'h01};
            end
         end
         default: r = {(lo == 8'hff), hi, lo + 8'h01};
      endcase
      return r;
   endfunction : dtc_step

   // Gate qualification with programmable polarity
   function automatic logic dtc_run(input logic run, input logic gate, input logic pin,
                                    input logic pol);
      return run && (!gate || (pin == pol));
   endfunction : dtc_run

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   dtc_prescaler u_pre (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .prescale_select_in(st.timer_clock_ctrl[1:0]),
      .ext_clk_fall_in(fall[4]),
      .tick_out(pre_tick)
   );

   // Falling edges: bit 0 t0 pin, 1 t1 pin, 4 ext clock; 2,3 gate inputs
   assign fall = st.s3 & ~st.s2;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [3:0] m0, m1;
   logic tick0, tick1, en0, en1, en0h;
   logic [16:0] r0, r1;
   logic [8:0] r0h;
   logic [DTC_IRQ_W-1:0] ev;

   always_comb begin
      next_st = st;
      m0 = st.timer_mode_ctrl[3:0];
      m1 = st.timer_mode_ctrl[7:4];
      // Synchronisers: s1 then s2, s3 only for edge detection
      next_st.s1 = {ext_clk_in, ext_input_one_in, ext_input_zero_in,
                    timer1_event_pin_in, timer0_event_pin_in};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      tick0 = m0[DTC_MODE_CSEL] ? fall[0] :
              (st.timer_clock_ctrl[DTC_CLK_T0_SEL] ? 1'b1 : pre_tick);
      tick1 = m1[DTC_MODE_CSEL] ? fall[1] :
              (st.timer_clock_ctrl[DTC_CLK_T1_SEL] ? 1'b1 : pre_tick);
      en0 = tick0 && dtc_run(st.timer_control_reg[DTC_CTL_T0_RUN], m0[DTC_MODE_GATE],
                             st.s2[2], st.ext_input_config[DTC_EXT_POL0]);
      // Split mode high byte runs from timer 1 run bit on the internal clock
      en0h = (m0[1:0] == DTC_MODE_SPLIT) && st.timer_control_reg[DTC_CTL_T1_RUN] &&
             (st.timer_clock_ctrl[DTC_CLK_T0_SEL] || pre_tick);
      en1 = tick1 && (m1[1:0] != DTC_MODE_SPLIT) &&
            dtc_run(st.timer_control_reg[DTC_CTL_T1_RUN], m1[DTC_MODE_GATE],
                    st.s2[3], st.ext_input_config[DTC_EXT_POL1]);
      r0 = dtc_step(m0[1:0], st.timer0_low_byte, st.timer0_high_byte);
      r1 = dtc_step(m1[1:0], st.timer1_low_byte, st.timer1_high_byte);
      r0h = {1'b0, st.timer0_high_byte} + 9'h0_01;
      ev = '0;
      if (en0) begin
         next_st.timer0_low_byte = r0[7:0];
         if (m0[1:0] != DTC_MODE_SPLIT) begin
            next_st.timer0_high_byte = r0[15:8];
         end
         ev[0] = r0[16];
      end
      if (en0h) begin
         next_st.timer0_high_byte = r0h[7:0];
         ev[2] = r0h[8];
      end
      if (en1) begin
         next_st.timer1_low_byte = r1[7:0];
         next_st.timer1_high_byte = r1[15:8];
         ev[1] = r1[16];
      end
      // Register writes
      if (wr_in) begin
         case (addr_in)
            DTC_OFF_MODE: next_st.timer_mode_ctrl = wdata_in;
            DTC_OFF_CLOCK: next_st.timer_clock_ctrl = wdata_in;
            DTC_OFF_CONTROL: next_st.timer_control_reg = wdata_in;
            DTC_OFF_EXTCFG: next_st.ext_input_config = wdata_in;
            DTC_OFF_T0_LOW: next_st.timer0_low_byte = wdata_in;
            DTC_OFF_T0_HIGH: next_st.timer0_high_byte = wdata_in;
            DTC_OFF_T1_LOW: next_st.timer1_low_byte = wdata_in;
            DTC_OFF_T1_HIGH: next_st.timer1_high_byte = wdata_in;
            DTC_OFF_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~wdata_in[DTC_IRQ_W-1:0];
            DTC_OFF_IRQ_MASK: next_st.irq_mask = wdata_in[DTC_IRQ_W-1:0];
            default: ;
         endcase
      end
      // Hardware set wins over any clear
      if (ev[0] || ev[2]) begin
         next_st.timer_control_reg[DTC_CTL_T0_FLAG] = ev[0] ||
            next_st.timer_control_reg[DTC_CTL_T0_FLAG];
      end
      if (ev[1] || ev[2]) begin
         next_st.timer_control_reg[DTC_CTL_T1_FLAG] = 1'b1;
      end
      if (ev[0]) begin
         next_st.timer_control_reg[DTC_CTL_T0_FLAG] = 1'b1;
      end
      next_st.irq_stat = next_st.irq_stat | ev;
      // Register reads
      next_st.rdata = DTC_RST_BYTE;
      if (rd_in) begin
         case (addr_in)
            DTC_OFF_MODE: next_st.rdata = st.timer_mode_ctrl;
            DTC_OFF_CLOCK: next_st.rdata = st.timer_clock_ctrl;
            DTC_OFF_CONTROL: next_st.rdata = st.timer_control_reg;
            DTC_OFF_EXTCFG: next_st.rdata = st.ext_input_config;
            DTC_OFF_T0_LOW: next_st.rdata = st.timer0_low_byte;
            DTC_OFF_T0_HIGH: next_st.rdata = st.timer0_high_byte;
            DTC_OFF_T1_LOW: next_st.rdata = st.timer1_low_byte;
            DTC_OFF_T1_HIGH: next_st.rdata = st.timer1_high_byte;
            DTC_OFF_IRQ_STAT: next_st.rdata = {5'h0_0, st.irq_stat};
            DTC_OFF_IRQ_MASK: next_st.rdata = {5'h0_0, st.irq_mask};
            default: next_st.rdata = DTC_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_out = st.rdata;
   assign irq_out = |(st.irq_stat & st.irq_mask);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_reload_value: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (en0 && m0[1:0] == DTC_MODE_RELOAD && st.timer0_low_byte == 8'hff && !wr_in)
      |=> st.timer0_low_byte == $past(st.timer0_high_byte)) else $error("no reload");
   a_reload_keeps_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (en0 && m0[1:0] == DTC_MODE_RELOAD && !wr_in)
      |=> $stable(st.timer0_high_byte)) else $error("reload byte changed");
   a_reload_flag_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (en0 && m0[1:0] == DTC_MODE_RELOAD && st.timer0_low_byte == 8'hff)
      |=> st.timer_control_reg[DTC_CTL_T0_FLAG]) else $error("flag not set");
   a_t1_reload: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (en1 && m1[1:0] == DTC_MODE_RELOAD && st.timer1_low_byte == 8'hff && !wr_in)
      |=> st.timer1_low_byte == $past(st.timer1_high_byte)) else $error("t1 reload");
   a_full_wrap: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (en0 && m0[1:0] == DTC_MODE_16 && {st.timer0_high_byte, st.timer0_low_byte} == 16'hffff)
      |=> st.irq_stat[0]) else $error("16-bit wrap missed");
   a_run_needed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!st.timer_control_reg[DTC_CTL_T0_RUN] && !wr_in)
      |=> $stable(st.timer0_low_byte)) else $error("timer 0 ran while stopped");
   a_gate_polarity: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (m0[DTC_MODE_GATE] && st.s2[2] != st.ext_input_config[DTC_EXT_POL0])
      |-> !en0) else $error("gate ignored");
   a_t1_halt: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (m1[1:0] == DTC_MODE_SPLIT) |-> !en1) else $error("timer 1 ran in halt");
   a_irq_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ev[0] && st.irq_mask[0]) |=> irq_out) else $error("irq missing");
   a_event_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (m0[DTC_MODE_CSEL] && !fall[0]) |-> !en0) else $error("counted without edge");
   a_sysclk_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!m0[DTC_MODE_CSEL] && st.timer_clock_ctrl[DTC_CLK_T0_SEL] && !m0[DTC_MODE_GATE] &&
       st.timer_control_reg[DTC_CTL_T0_RUN] && m0[1:0] == DTC_MODE_16 && !wr_in)
      |=> st.timer0_low_byte == $past(st.timer0_low_byte) + 8'h01)
      else $error("system clock select ignored");

   c_reload: cover property (@(posedge sys_clk_in) en0 && m0[1:0] == DTC_MODE_RELOAD && r0[16]);
   c_t1_over: cover property (@(posedge sys_clk_in) ev[1]);
   c_irq: cover property (@(posedge sys_clk_in) irq_out);
   c_split: cover property (@(posedge sys_clk_in) ev[2]);
endmodule : dtc_timer
`default_nettype wire

// ### core/dtc_pkg.sv
/*
 * Constants for the dual counter/timer block: register offsets, field positions, reset values
 * and prescale divide counts.
 * Assumes a 40 MHz system clock and a plain address/strobe register port.
 */
// Notes on behaviour
// - Mode 1 counts with the full 16-bit register pair and is enabled like mode 0.
// - Mode 2 uses the low byte as an 8-bit count and the high byte as its reload value.
// - On a low-byte wrap in mode 2 the overflow flag is set and the low byte reloads at once.
// - An enabled timer interrupt is raised whenever a counter overflow sets the overflow flag.
// - A reload never changes the high-byte reload value.
// - Timer 1 in mode 2 behaves like timer 0 with its own bytes, flag and interrupt.
// - A timer counts only with its run bit set, and with gating on also needs its input active; the split high byte uses the timer 1 run bit, ungated.
// - The gate input's active level comes from a programmable polarity bit.
// - Mode field: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 timer 1 halt or timer 0 split.
`default_nettype none
package dtc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] DTC_OFF_MODE = 8'h89;
   localparam logic [7:0] DTC_OFF_CLOCK = 8'h8E;
   localparam logic [7:0] DTC_OFF_CONTROL = 8'h88;
   localparam logic [7:0] DTC_OFF_EXTCFG = 8'hE4;
   localparam logic [7:0] DTC_OFF_T0_LOW = 8'h8A;
   localparam logic [7:0] DTC_OFF_T1_LOW = 8'h8B;
   localparam logic [7:0] DTC_OFF_T0_HIGH = 8'h8C;
   localparam logic [7:0] DTC_OFF_T1_HIGH = 8'h8D;
   localparam logic [7:0] DTC_OFF_IRQ_STAT = 8'hA0;
   localparam logic [7:0] DTC_OFF_IRQ_MASK = 8'hA1;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   // Mode register, timer 0 in low nibble, timer 1 in high nibble
   localparam int DTC_MODE_T1_BASE = 4;
   localparam int DTC_MODE_GATE = 3;
   localparam int DTC_MODE_CSEL = 2;
   // Clock register
   localparam int DTC_CLK_T1_SEL = 3;
   localparam int DTC_CLK_T0_SEL = 2;
   // Control register
   localparam int DTC_CTL_T1_FLAG = 7;
   localparam int DTC_CTL_T1_RUN = 6;
   localparam int DTC_CTL_T0_FLAG = 5;
   localparam int DTC_CTL_T0_RUN = 4;
   // Ext input config
   localparam int DTC_EXT_POL1 = 7;
   localparam int DTC_EXT_POL0 = 3;
   // ----------------------------------------
   // Mode and prescale codes
   // ----------------------------------------
   localparam logic [1:0] DTC_MODE_13 = 2'h0;
   localparam logic [1:0] DTC_MODE_16 = 2'h1;
   localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
   localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;
   localparam logic [1:0] DTC_PRE_DIV12 = 2'h0;
   localparam logic [1:0] DTC_PRE_DIV4 = 2'h1;
   localparam logic [1:0] DTC_PRE_DIV48 = 2'h2;
   localparam logic [1:0] DTC_PRE_EXT8 = 2'h3;
   localparam logic [5:0] DTC_DIV12 = 6'h0_c;
   localparam logic [5:0] DTC_DIV4 = 6'h0_4;
   localparam logic [5:0] DTC_DIV48 = 6'h3_0;
   localparam logic [5:0] DTC_DIV8 = 6'h0_8;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] DTC_RST_BYTE = 8'h00;
   // Irq bits: 0 timer0 overflow, 1 timer1 overflow, 2 timer0 high-byte overflow (split)
   localparam int DTC_IRQ_W = 3;
endpackage : dtc_pkg
`default_nettype wire

// ### core/dtc_prescaler.sv
/*
 * Prescaled count enable: one-cycle pulse every N system clocks, or every 8 falling
 * edges of the external clock.
 * Assumes ext_clk_fall_in is already synchronised and is a one-cycle pulse.
 */
`default_nettype none
module dtc_prescaler
   import dtc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Control
   input wire logic [1:0] prescale_select_in,
   input wire logic ext_clk_fall_in,
   // Enable out
   output logic tick_out
);
   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } dtc_pre_state_t;

   dtc_pre_state_t st, next_st;
   logic [5:0] limit;
   logic step;

   always_comb begin
      next_st = st;
      case (prescale_select_in)
         DTC_PRE_DIV12: limit = DTC_DIV12;
         DTC_PRE_DIV4: limit = DTC_DIV4;
         DTC_PRE_DIV48: limit = DTC_DIV48;
         default: limit = DTC_DIV8;
      endcase
      step = (prescale_select_in == DTC_PRE_EXT8) ? ext_clk_fall_in : 1'b1;
      next_st.tick = 1'b0;
      if (step) begin
         if (st.cnt >= limit - 6'h0_1) begin
            next_st.cnt = 6'h0_0;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 6'h0_1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_out = st.tick;

   a_pre_tick_single: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      tick_out |=> !tick_out) else $error("prescale tick longer than one cycle");
endmodule : dtc_prescaler
`default_nettype wire

// ### bench/dtc_pin_model.sv
/* Pin model: event pins, gate inputs and external clock of the counter/timers.
   Assumes its tasks are called just after a rising edge of clk_in. */
`default_nettype none
module dtc_pin_model (
   // Clock
   input wire logic clk_in,
   // Pins
   output logic ev0_out,
   output logic ev1_out,
   output logic timer0_gating_bit_out,
   output logic timer1_gating_bit_out,
   output logic ext_clk_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ev = 2'h3;
   logic [1:0] gate = 2'h0;
   logic ext = 1'b1;
   assign ev0_out = ev[0];
   assign ev1_out = ev[1];
   assign timer0_gating_bit_out = gate[0];
   assign timer1_gating_bit_out = gate[1];
   assign ext_clk_out = ext;
   task automatic set_gate(input int idx, input logic lvl);
      gate[idx] <= lvl;
   endtask : set_gate
   // Falling edges spaced well beyond the pin synchronisers
   task automatic pulse_events(input int idx, input int n);
      for (int i = 0; i < n; i++) begin
         ev[idx] <= 1'b0;
         repeat (4) @(posedge clk_in);
         ev[idx] <= 1'b1;
         repeat (4) @(posedge clk_in);
      end
   endtask : pulse_events
   // Clock stands high outside bursts
   task automatic ext_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         ext <= 1'b0;
         repeat (2) @(posedge clk_in);
         ext <= 1'b1;
         repeat (2) @(posedge clk_in);
      end
   endtask : ext_clocks
endmodule : dtc_pin_model
`default_nettype wire

// ### bench/dual_timer_counter_modes_tb.sv
/* Self-checking bench for the dual counter/timer: registers, modes, gating, count
   select and prescale. Assumes dtc_pkg, dtc_timer and dtc_pin_model are compiled. */
`default_nettype none
module dual_timer_counter_modes_tb
   import dtc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} dtc_row_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic irq, ev0, ev1, timer0_gating_bit, timer1_gating_bit, ext_clk;
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] v;
   dtc_row_t rows [12] = '{'{8'h89, 8'hA5, 8'hA5}, '{8'h88, 8'h0F, 8'h0F},
      '{8'h8E, 8'h0F, 8'h0F}, '{8'hE4, 8'h88, 8'h88}, '{8'h8C, 8'h5A, 8'h5A},
      '{8'h8D, 8'hC3, 8'hC3}, '{8'h8A, 8'h3C, 8'h3C}, '{8'h8B, 8'h96, 8'h96},
      '{8'hA1, 8'h07, 8'h07}, '{8'hA0, 8'h07, 8'h00}, '{8'h00, 8'h55, 8'h00},
      '{8'hFF, 8'hAA, 8'h00}};
   // Mode, run, gate level, polarity, counting expected
   logic [11:0] grows [6] = '{12'h090, 12'h099, 12'h09C, 12'h09F, 12'h09A, 12'h01D};
   // Prescale code, expected count
   logic [11:0] prows [4] = '{12'h008, 12'h118, 12'h202, 12'h304};
   always #12.5 sys_clk = ~sys_clk;
   dtc_timer u_dtc_timer (.sys_clk_in(sys_clk), .rst_in(rst), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .timer0_event_pin_in(ev0), .timer1_event_pin_in(ev1), .ext_input_zero_in(timer0_gating_bit),
      .ext_input_one_in(timer1_gating_bit), .ext_clk_in(ext_clk), .irq_out(irq));
   dtc_pin_model u_dtc_pin_model (.clk_in(sys_clk), .ev0_out(ev0), .ev1_out(ev1),
      .timer0_gating_bit_out(timer0_gating_bit), .timer1_gating_bit_out(timer1_gating_bit), .ext_clk_out(ext_clk));
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge sys_clk);
   endtask : rd_reg
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic check_range(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi,
      input string what);
      total_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h outside %h..%h", $time, what, got, lo, hi);
      end
   endtask : check_range
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 4) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check({7'h00, irq}, {7'h00, lvl}, "irq level");
      if (irq !== lvl) complete_run();
      @(posedge sys_clk);
   endtask : wait_irq
   task automatic do_reset();
      rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_reset
   task automatic reload_case(input int t);
      logic [7:0] lo_a, hi_a, fm, sb;
      lo_a = t ? DTC_OFF_T1_LOW : DTC_OFF_T0_LOW;
      hi_a = t ? DTC_OFF_T1_HIGH : DTC_OFF_T0_HIGH;
      fm = t ? 8'hC0 : 8'h30;
      sb = t ? 8'h02 : 8'h01;
      wr_reg(DTC_OFF_MODE, t ? 8'h20 : 8'h02);
      wr_reg(DTC_OFF_CLOCK, t ? 8'h08 : 8'h04);
      wr_reg(hi_a, 8'hFC);
      wr_reg(lo_a, 8'hFE);
      wr_reg(DTC_OFF_CONTROL, fm & 8'h50);
      repeat (20) @(posedge sys_clk);
      rd_reg(DTC_OFF_CONTROL, v);
      check(v & fm, fm, "flag and run");
      wr_reg(DTC_OFF_CONTROL, 8'h00);
      rd_reg(DTC_OFF_IRQ_STAT, v);
      check(v, sb, "status");
      check({7'h00, irq}, 8'h00, "masked irq");
      rd_reg(hi_a, v);
      check(v, 8'hFC, "reload byte");
      rd_reg(lo_a, v);
      check_range(v, 8'hFC, 8'hFF, "count byte");
      wr_reg(DTC_OFF_IRQ_MASK, sb);
      wait_irq(1'b1);
      wr_reg(DTC_OFF_IRQ_STAT, sb);
      wait_irq(1'b0);
   endtask : reload_case
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      do_reset();
      for (int i = 0; i < 12; i++) begin
         rd_reg(rows[i].addr, v);
         check(v, 8'h00, "reset value");
         wr_reg(rows[i].addr, rows[i].wdata);
         rd_reg(rows[i].addr, v);
         check(v, rows[i].exp, "readback");
      end
      $display("Register table done");
      for (int t = 0; t < 2; t++) begin
         do_reset();
         reload_case(t);
      end
      $display("Auto-reload done");
      for (int m = 0; m < 2; m++) begin
         do_reset();
         wr_reg(DTC_OFF_MODE, 8'(m));
         wr_reg(DTC_OFF_CLOCK, 8'h04);
         wr_reg(DTC_OFF_T0_LOW, m ? 8'hF0 : 8'h10);
         wr_reg(DTC_OFF_CONTROL, 8'h10);
         repeat (40) @(posedge sys_clk);
         wr_reg(DTC_OFF_CONTROL, 8'h00);
         rd_reg(DTC_OFF_T0_HIGH, v);
         check(v, 8'h01, "carry into high byte");
         rd_reg(DTC_OFF_T0_LOW, v);
         check_range(v & 8'h1F, 8'h16, 8'h1E, "low count");
         rd_reg(DTC_OFF_CONTROL, v);
         check(v & 8'h20, 8'h00, "no flag");
      end
      do_reset();
      wr_reg(DTC_OFF_MODE, 8'h30);
      wr_reg(DTC_OFF_CLOCK, 8'h08);
      wr_reg(DTC_OFF_CONTROL, 8'h40);
      repeat (20) @(posedge sys_clk);
      rd_reg(DTC_OFF_T1_LOW, v);
      check(v, 8'h00, "halted timer");
      do_reset();
      wr_reg(DTC_OFF_MODE, 8'h03);
      wr_reg(DTC_OFF_CLOCK, 8'h04);
      wr_reg(DTC_OFF_T0_HIGH, 8'hF0);
      wr_reg(DTC_OFF_CONTROL, 8'h50);
      repeat (20) @(posedge sys_clk);
      wr_reg(DTC_OFF_CONTROL, 8'h00);
      rd_reg(DTC_OFF_T0_HIGH, v);
      check_range(v, 8'h05, 8'h07, "split high byte");
      rd_reg(DTC_OFF_T0_LOW, v);
      check_range(v, 8'h15, 8'h17, "split low byte");
      rd_reg(DTC_OFF_IRQ_STAT, v);
      check(v, 8'h04, "split overflow status");
      wr_reg(DTC_OFF_IRQ_MASK, 8'h04);
      check({7'h00, irq}, 8'h01, "split irq");
      // Mid-run reset clears status and interrupt
      do_reset();
      check({7'h00, irq}, 8'h00, "irq after reset");
      rd_reg(DTC_OFF_IRQ_STAT, v);
      check(v, 8'h00, "status after reset");
      $display("Modes done");
      do_reset();
      for (int i = 0; i < 6; i++) begin
         u_dtc_pin_model.set_gate(0, grows[i][2]);
         wr_reg(DTC_OFF_EXTCFG, {4'h0, grows[i][1], 3'h0});
         wr_reg(DTC_OFF_MODE, grows[i][11:4]);
         wr_reg(DTC_OFF_CLOCK, 8'h04);
         wr_reg(DTC_OFF_T0_LOW, 8'h00);
         wr_reg(DTC_OFF_CONTROL, {3'h0, grows[i][3], 4'h0});
         repeat (20) @(posedge sys_clk);
         wr_reg(DTC_OFF_CONTROL, 8'h00);
         rd_reg(DTC_OFF_T0_LOW, v);
         check({7'h00, v != 8'h00}, {7'h00, grows[i][0]}, "gated count");
      end
      $display("Gating done");
      for (int t = 0; t < 2; t++) begin
         do_reset();
         wr_reg(DTC_OFF_MODE, t ? 8'h50 : 8'h05);
         wr_reg(DTC_OFF_CONTROL, t ? 8'h40 : 8'h10);
         u_dtc_pin_model.pulse_events(t, 5);
         wr_reg(DTC_OFF_CONTROL, 8'h00);
         rd_reg(t ? DTC_OFF_T1_LOW : DTC_OFF_T0_LOW, v);
         check(v, 8'h05, "event count");
      end
      $display("Counter function done");
      for (int i = 0; i < 4; i++) begin
         do_reset();
         wr_reg(DTC_OFF_MODE, 8'h01);
         wr_reg(DTC_OFF_CLOCK, {6'h00, prows[i][9:8]});
         wr_reg(DTC_OFF_CONTROL, 8'h10);
         if (i == 3) begin
            u_dtc_pin_model.ext_clocks(32);
         end else begin
            repeat (96) @(posedge sys_clk);
         end
         wr_reg(DTC_OFF_CONTROL, 8'h00);
         rd_reg(DTC_OFF_T0_LOW, v);
         check_range(v, prows[i][7:0] - 8'h01, prows[i][7:0] + 8'h01, "prescaled");
      end
      $display("Prescale done");
      complete_run();
   end
endmodule : dual_timer_counter_modes_tb
`default_nettype wire
